// ### rtl/dwd_pkg.sv
// package: shared constants and carriers of the dual watchdog system
package dwd_pkg;
	localparam int unsigned WIN_W        = 7;
	localparam int unsigned IND_W        = 12;
	localparam logic [6:0]  WIN_RST_CNT  = 7'h7f;
	localparam logic [6:0]  WIN_RST_WIN  = 7'h7f;
	localparam logic [6:0]  WIN_TIMEOUT  = 7'h3f;
	localparam logic [11:0] IND_RST_LOAD = 12'hfff;
	localparam logic [11:0] IND_END      = 12'h000;
	localparam logic [7:0]  KEY_REFRESH  = 8'haa;
	localparam logic [7:0]  KEY_START    = 8'hcc;
	localparam int unsigned LSRC_KHZ     = 128;
	localparam int unsigned CLK_KHZ      = 100000;
	localparam int unsigned WIN_TICK_CYC = 12288;
	localparam int unsigned CLK_MHZ_X10  = 1000;

	typedef enum logic [1:0] {
		DWD_IDLE,
		DWD_RUN,
		DWD_FIRE
	} dwd_state_t;

	typedef struct packed {
		logic       start;
		logic       refresh;
		logic [6:0] load;
		logic [6:0] window;
	} dwd_win_cmd_t;

	typedef struct packed {
		logic       key_wr;
		logic [7:0] key;
		logic [11:0] reload;
	} dwd_ind_cmd_t;
endpackage

// ### rtl/dwd_ind.sv
// independent watchdog counter clocked by the low speed rc oscillator
module dwd_ind
	import dwd_pkg::*;
(
	input  wire logic         osc_clk_i,   // low_speed_rc_osc clock
	input  wire logic         resetn_i,    // async reset, active low
	input  wire logic         hw_opt_i,    // hardware watchdog option
	input  wire dwd_ind_cmd_t cmd_i,       // key and reload value
	output logic              active_o,    // watchdog running
	output logic [IND_W-1:0]  count_o,     // current count
	output logic              rst_req_o    // reset request
);
	dwd_state_t       state;
	dwd_state_t       next_state;
	logic [IND_W-1:0] count;
	logic [IND_W-1:0] next_count;
	logic             hw_seen;
	logic             next_hw_seen;

	always_comb begin
		next_state   = state;
		next_count   = count;
		next_hw_seen = 1'b1;
		unique case (state)
			DWD_IDLE: begin
				// option caught once after reset release
				// option start keeps the reset load, a key start takes the reload field
				if (!hw_seen && hw_opt_i) begin
					next_state = DWD_RUN;
				end else if (cmd_i.key_wr && cmd_i.key == KEY_START) begin
					next_state = DWD_RUN;
					next_count = cmd_i.reload;
				end
			end
			DWD_RUN: begin
				// key values other than refresh never stop it
				if (cmd_i.key_wr && cmd_i.key == KEY_REFRESH) begin
					next_count = cmd_i.reload;
				end else if (count == IND_END) begin
					next_state = DWD_FIRE;
				end else begin
					next_count = count - 1'b1;
				end
			end
			DWD_FIRE: begin
				next_state = DWD_FIRE;
			end
			default: next_state = DWD_IDLE;
		endcase
	end

	always_ff @(posedge osc_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state   <= DWD_IDLE;
			count   <= IND_RST_LOAD;
			hw_seen <= 1'b0;
		end else begin
			state   <= next_state;
			count   <= next_count;
			hw_seen <= next_hw_seen;
		end
	end

	assign active_o  = (state != DWD_IDLE);
	assign count_o   = count;
	assign rst_req_o = (state == DWD_FIRE);
endmodule

// ### rtl/dwd_top.sv
// dual watchdog system: window watchdog plus independent watchdog
// Operation
// - software cannot stop a running watchdog
// - start by software write or option
// - refresh outside window resets device
// - no refresh before timeout resets device
// - independent counter runs on rc oscillator
// - hardware option starts independent watchdog
// - independent count end resets device
module dwd_top
	import dwd_pkg::*;
(
	input  wire logic         clk_i,        // 100 MHz system clock
	input  wire logic         resetn_i,     // async reset, active low
	input  wire logic         osc_clk_i,    // low_speed_rc_osc clock
	input  wire logic         win_hw_opt_i, // window watchdog option
	input  wire logic         ind_hw_opt_i, // independent watchdog option
	input  wire dwd_win_cmd_t win_cmd_i,    // window start/refresh
	input  wire dwd_ind_cmd_t ind_cmd_i,    // independent key write
	output logic              win_active_o, // window watchdog running
	output logic [WIN_W-1:0]  win_count_o,  // window counter
	output logic              ind_active_o, // independent running
	output logic [IND_W-1:0]  ind_count_o,  // independent counter
	output logic              dev_reset_o   // device reset request
);
	dwd_state_t       state;
	dwd_state_t       next_state;
	logic [WIN_W-1:0] count;
	logic [WIN_W-1:0] next_count;
	logic [WIN_W-1:0] window;
	logic [WIN_W-1:0] next_window;
	logic [13:0]      tick;
	logic [13:0]      next_tick;
	logic             hw_seen;
	logic             next_hw_seen;
	logic             ind_fire;
	logic             tick_hit;

	assign tick_hit = (tick == 14'(WIN_TICK_CYC - 1));

	always_comb begin
		next_state   = state;
		next_count   = count;
		next_window  = window;
		next_tick    = tick_hit ? 14'h0000 : tick + 14'h0001;
		next_hw_seen = 1'b1;
		unique case (state)
			DWD_IDLE: begin
				next_tick = 14'h0000;
				if (!hw_seen && win_hw_opt_i) begin
					next_state = DWD_RUN;
				end else if (win_cmd_i.start) begin
					next_state  = DWD_RUN;
					next_count  = win_cmd_i.load;
					next_window = win_cmd_i.window;
				end
			end
			DWD_RUN: begin
				// a cleared start bit is ignored while running
				// time-out wins over a refresh that arrives too late
				if (count <= WIN_TIMEOUT) begin
					next_state = DWD_FIRE;
				end else if (win_cmd_i.refresh) begin
					if (count > window) begin
						next_state = DWD_FIRE;
					end else begin
						next_count  = win_cmd_i.load;
						next_window = win_cmd_i.window;
						next_tick   = 14'h0000;
					end
				end else if (tick_hit) begin
					next_count = count - 7'h01;
				end
			end
			DWD_FIRE: begin
				next_state = DWD_FIRE;
			end
			default: next_state = DWD_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state   <= DWD_IDLE;
			count   <= WIN_RST_CNT;
			window  <= WIN_RST_WIN;
			tick    <= 14'h0000;
			hw_seen <= 1'b0;
		end else begin
			state   <= next_state;
			count   <= next_count;
			window  <= next_window;
			tick    <= next_tick;
			hw_seen <= next_hw_seen;
		end
	end

	dwd_ind u_ind (
		.osc_clk_i (osc_clk_i),
		.resetn_i  (resetn_i),
		.hw_opt_i  (ind_hw_opt_i),
		.cmd_i     (ind_cmd_i),
		.active_o  (ind_active_o),
		.count_o   (ind_count_o),
		.rst_req_o (ind_fire)
	);

	assign win_active_o = (state != DWD_IDLE);
	assign win_count_o  = count;
	// independent request is a steady level, passed unsynchronised
	assign dev_reset_o  = (state == DWD_FIRE) || ind_fire;
endmodule

// ### bench/dwd_monitor.sv
// checker: port properties of the dual watchdog
module dwd_monitor
	import dwd_pkg::*;
(
	input wire logic             clk_i,        // clock
	input wire logic             resetn_i,     // reset
	input wire logic             osc_clk_i,    // rc clock
	input wire logic             win_hw_opt_i, // option
	input wire logic             ind_hw_opt_i, // option
	input wire dwd_win_cmd_t     win_cmd_i,    // command
	input wire dwd_ind_cmd_t     ind_cmd_i,    // key
	input wire logic             win_active_o, // running
	input wire logic [WIN_W-1:0] win_count_o,  // count
	input wire logic             ind_active_o, // running
	input wire logic [IND_W-1:0] ind_count_o,  // count
	input wire logic             dev_reset_o   // reset out
);
	timeunit 1ns;
	timeprecision 1ps;
	chk_win_kept:
	assert property (@(posedge clk_i) disable iff (!resetn_i) win_active_o |=> win_active_o)
		else $error("window watchdog stopped");
	chk_ind_kept:
	assert property (@(posedge osc_clk_i) disable iff (!resetn_i) ind_active_o |=> ind_active_o)
		else $error("independent watchdog stopped");
	chk_fire_held:
	assert property (@(posedge clk_i) disable iff (!resetn_i) dev_reset_o |=> dev_reset_o)
		else $error("reset request dropped");
	chk_win_timeout:
	assert property (@(posedge clk_i) disable iff (!resetn_i)
		win_active_o && win_count_o <= WIN_TIMEOUT |=> dev_reset_o) else $error("no timeout reset");
	chk_opt_start:
	assert property (@(posedge clk_i) disable iff (!resetn_i)
		$rose(resetn_i) && win_hw_opt_i |-> ##[0:2] win_active_o) else $error("option start missed");
	chk_win_down:
	assert property (@(posedge clk_i) disable iff (!resetn_i) $changed(win_count_o)
		&& !$past(win_cmd_i.refresh) && !$past(win_cmd_i.start) |-> win_count_o == $past(win_count_o) - 7'h01)
		else $error("window count step wrong");
	chk_ind_down:
	assert property (@(posedge osc_clk_i) disable iff (!resetn_i) $changed(ind_count_o)
		&& !$past(ind_cmd_i.key_wr) |-> ind_count_o == $past(ind_count_o) - 12'h001)
		else $error("independent count step wrong");
	chk_ind_end:
	assert property (@(posedge osc_clk_i) disable iff (!resetn_i) ind_active_o
		&& ind_count_o == IND_END && !ind_cmd_i.key_wr |-> ##[1:2] dev_reset_o) else $error("no end reset");
endmodule

bind dwd_top dwd_monitor i_mon (
	.clk_i        (clk_i),
	.resetn_i     (resetn_i),
	.osc_clk_i    (osc_clk_i),
	.win_hw_opt_i (win_hw_opt_i),
	.ind_hw_opt_i (ind_hw_opt_i),
	.win_cmd_i    (win_cmd_i),
	.ind_cmd_i    (ind_cmd_i),
	.win_active_o (win_active_o),
	.win_count_o  (win_count_o),
	.ind_active_o (ind_active_o),
	.ind_count_o  (ind_count_o),
	.dev_reset_o  (dev_reset_o)
);

// ### bench/dual_watchdog_system_test.sv
// testbench: directed scenarios for the dual watchdog
module dual_watchdog_system_test
	import dwd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, resetn_i = 0, osc_clk_i = 0, win_hw_opt_i = 0, ind_hw_opt_i = 0;
	logic win_active_o, ind_active_o, dev_reset_o;
	logic [WIN_W-1:0] win_count_o;
	logic [IND_W-1:0] ind_count_o;
	dwd_win_cmd_t win_cmd_i = '0;
	dwd_ind_cmd_t ind_cmd_i = '0;
	int failures = 0;
	int checks = 0;
	always #5 clk_i = ~clk_i;
	always #3906 osc_clk_i = ~osc_clk_i;
	dwd_top i_dut (
		.clk_i        (clk_i),
		.resetn_i     (resetn_i),
		.osc_clk_i    (osc_clk_i),
		.win_hw_opt_i (win_hw_opt_i),
		.ind_hw_opt_i (ind_hw_opt_i),
		.win_cmd_i    (win_cmd_i),
		.ind_cmd_i    (ind_cmd_i),
		.win_active_o (win_active_o),
		.win_count_o  (win_count_o),
		.ind_active_o (ind_active_o),
		.ind_count_o  (ind_count_o),
		.dev_reset_o  (dev_reset_o)
	);
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rst(input logic wo, input logic io);
		resetn_i <= 0;
		win_hw_opt_i <= wo;
		ind_hw_opt_i <= io;
		@(posedge osc_clk_i);
		repeat (6) @(posedge clk_i);
		resetn_i <= 1;
	endtask
	task automatic wp(input dwd_win_cmd_t c);
		@(posedge clk_i) win_cmd_i <= c;
		@(posedge clk_i) win_cmd_i <= '0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic kp(input logic [7:0] k);
		@(posedge osc_clk_i) ind_cmd_i <= '{1'b1, k, 12'h008};
		@(posedge osc_clk_i) ind_cmd_i <= '0;
		repeat (2) @(posedge osc_clk_i);
		#1;
	endtask
	task automatic t_win;
		rst(0, 0);
		wp('{1'b1, 1'b0, 7'h7f, 7'h50});
		cmp(win_active_o, 12'h001);
		wp('{1'b1, 1'b0, 7'h10, 7'h7f});
		cmp(win_count_o, 12'h07f);
		wp('{1'b0, 1'b1, 7'h7f, 7'h50});
		cmp(dev_reset_o, 12'h001);
		$display("t_win done");
	endtask
	// valid refresh reloads, then one missed tick runs into the time-out
	task automatic t_tmo;
		rst(0, 0);
		wp('{1'b1, 1'b0, 7'h41, 7'h7f});
		cmp(win_count_o, 12'h041);
		wp('{1'b0, 1'b1, 7'h40, 7'h7f});
		cmp(win_count_o, 12'h040);
		cmp(dev_reset_o, 12'h000);
		repeat (12284) @(posedge clk_i);
		#1 cmp(win_count_o, 12'h040);
		cmp(dev_reset_o, 12'h000);
		repeat (4) @(posedge clk_i);
		#1 cmp(win_count_o, 12'h03f);
		cmp(dev_reset_o, 12'h001);
		$display("t_tmo done");
	endtask
	task automatic t_ind;
		rst(0, 0);
		kp(KEY_START);
		cmp(ind_count_o, 12'h006);
		kp(KEY_REFRESH);
		cmp(ind_count_o, 12'h006);
		cmp(dev_reset_o, 12'h000);
		repeat (20) @(posedge osc_clk_i);
		#1 cmp(dev_reset_o, 12'h001);
		cmp(ind_active_o, 12'h001);
		$display("t_ind done");
	endtask
	task automatic t_opt;
		rst(1, 1);
		repeat (3) @(posedge osc_clk_i);
		#1 cmp(win_active_o, 12'h001);
		cmp(ind_active_o, 12'h001);
		cmp(ind_count_o, 12'hffd);
		cmp(dev_reset_o, 12'h000);
		$display("t_opt done");
	endtask
	task automatic conclude;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		t_win;
		t_tmo;
		t_ind;
		t_opt;
		conclude;
	end
	initial begin
		#700000;
		failures++;
		conclude;
	end
endmodule
